//--- core/rtar_pkg.sv
// Constants and types for the per-port alias remap decoder
package rtar_pkg;
  localparam int NUM_PORTS = 4;
  localparam int NUM_SLOTS = 5;
  localparam logic [7:0] OFS_PORT_SEL = 8'h4C;
  localparam logic [7:0] OFS_ALIAS_TWO = 8'h67;
  localparam logic [7:0] OFS_ALIAS_THREE = 8'h68;
  localparam logic [7:0] OFS_ALIAS_FOUR = 8'h69;
  localparam logic [7:0] OFS_ALIAS_FIVE = 8'h6A;
  localparam logic [7:0] OFS_ALIAS_SIX = 8'h6B;
  localparam logic [7:0] ALIAS_RESET = 8'h00;
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 1;
  localparam int AUTO_ACK_BIT = 0;
  localparam logic [6:0] ALIAS_OFF = 7'h00;
  typedef logic [1:0] rtar_port_type;
  typedef logic [2:0] rtar_slot_type;
endpackage

//--- core/rtar_remap.sv
// Alias decoder and address remapper for targets behind the remote serializers
`timescale 1ns/1ns
module rtar_remap (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic REG_WR,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic [1:0] PORT_SEL,
  input wire logic [4:0][7:0] TARGET_ID,
  input wire logic TXN_VALID,
  input wire logic [6:0] TXN_ADDR,
  input wire logic TXN_RNW,
  input wire rtar_pkg::rtar_port_type TXN_PORT,
  output logic FWD_VALID,
  output logic [6:0] FWD_ADDR,
  output logic FWD_RNW,
  output logic AUTO_ACK,
  output logic MISS
);
  import rtar_pkg::*;

  logic [7:0] alias_reg [NUM_PORTS][NUM_SLOTS];
  logic hit;
  logic [6:0] hit_addr;
  logic hit_ack;

  // Maps a register offset onto a slot index; 7 means no slot
  function automatic rtar_slot_type slot_of(input logic [7:0] ofs);
    case (ofs)
      OFS_ALIAS_TWO: slot_of = 3'd0;
      OFS_ALIAS_THREE: slot_of = 3'd1;
      OFS_ALIAS_FOUR: slot_of = 3'd2;
      OFS_ALIAS_FIVE: slot_of = 3'd3;
      OFS_ALIAS_SIX: slot_of = 3'd4;
      default: slot_of = 3'd7;
    endcase
  endfunction

  // --------------------------------------------------
  // Alias register file
  // --------------------------------------------------
  // Register side is already on CLK_SYS, so no synchroniser
  genvar gp, gs;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      for (gs = 0; gs < NUM_SLOTS; gs++) begin : g_slot
        always_ff @(posedge CLK_SYS) begin
          if (RST) begin
            alias_reg[gp][gs] <= ALIAS_RESET;
          end else if (REG_WR && PORT_SEL == 2'(gp) && slot_of(REG_ADDR) == 3'(gs)) begin
            alias_reg[gp][gs] <= REG_WDATA;
          end
        end
      end
    end
  endgenerate

  // --------------------------------------------------
  // Register read-back
  // --------------------------------------------------
  // Unmapped offsets read as zero rather than aliasing a slot
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      REG_RDATA <= ALIAS_RESET;
    end else if (slot_of(REG_ADDR) != 3'd7) begin
      REG_RDATA <= alias_reg[PORT_SEL][slot_of(REG_ADDR)];
    end else begin
      REG_RDATA <= ALIAS_RESET;
    end
  end

  // --------------------------------------------------
  // Alias decode
  // --------------------------------------------------
  // Lowest slot wins if software programs the same alias twice
  always_comb begin
    hit = 1'b0;
    hit_addr = 7'h00;
    hit_ack = 1'b0;
    for (int s = NUM_SLOTS - 1; s >= 0; s--) begin
      if (alias_reg[TXN_PORT][s][ADDR_MSB:ADDR_LSB] != ALIAS_OFF &&
          alias_reg[TXN_PORT][s][ADDR_MSB:ADDR_LSB] == TXN_ADDR) begin
        hit = 1'b1;
        hit_addr = TARGET_ID[s][ADDR_MSB:ADDR_LSB];
        hit_ack = alias_reg[TXN_PORT][s][AUTO_ACK_BIT];
      end
    end
  end

  // --------------------------------------------------
  // Forward side
  // --------------------------------------------------
  // Every output is a flop, so each answer lands one edge after its request
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      FWD_VALID <= 1'b0;
    end else begin
      FWD_VALID <= TXN_VALID && hit;
    end
  end

  // Zero on a miss so a stray address never leaks toward the remote side
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      FWD_ADDR <= ALIAS_OFF;
    end else begin
      FWD_ADDR <= hit ? hit_addr : ALIAS_OFF;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      FWD_RNW <= 1'b0;
    end else begin
      FWD_RNW <= TXN_RNW;
    end
  end

  // Reads are never answered here; the remote target must answer them
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      AUTO_ACK <= 1'b0;
    end else begin
      AUTO_ACK <= TXN_VALID && hit && hit_ack && !TXN_RNW;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      MISS <= 1'b0;
    end else begin
      MISS <= TXN_VALID && !hit;
    end
  end

  // --------------------------------------------------
  // Checks
  // --------------------------------------------------
  // Outputs of one request
  a_miss_no_fwd: assert property (@(posedge CLK_SYS) disable iff (RST) MISS |-> !FWD_VALID)
    else $error("Forward on miss");
  a_ack_only_write: assert property (@(posedge CLK_SYS) disable iff (RST) AUTO_ACK |-> FWD_VALID && !FWD_RNW)
    else $error("Auto ack on read or idle");
  a_zero_addr_miss: assert property (@(posedge CLK_SYS) disable iff (RST)
    TXN_VALID && TXN_ADDR == 7'h00 |=> !FWD_VALID)
    else $error("Zero alias matched");
  a_fwd_follows_hit: assert property (@(posedge CLK_SYS) disable iff (RST)
    TXN_VALID && hit |=> FWD_VALID && FWD_ADDR == $past(hit_addr))
    else $error("Remap lost");
  a_reset_clear: assert property (@(posedge CLK_SYS) $past(RST) |-> REG_RDATA == 8'h00 && !FWD_VALID)
    else $error("Reset state wrong");
  a_read_port: assert property (@(posedge CLK_SYS) disable iff (RST)
    REG_ADDR == OFS_ALIAS_TWO && !REG_WR ##1 !$past(REG_WR) |-> REG_RDATA == alias_reg[$past(PORT_SEL)][0])
    else $error("Port copy read wrong");
  a_hit_match: assert property (@(posedge CLK_SYS) disable iff (RST)
    hit |-> TXN_ADDR != 7'h00)
    else $error("Hit on zero address");
  a_target_field: assert property (@(posedge CLK_SYS) disable iff (RST)
    TXN_VALID && hit && alias_reg[TXN_PORT][0][ADDR_MSB:ADDR_LSB] == TXN_ADDR
    |=> FWD_ADDR == $past(TARGET_ID[0][ADDR_MSB:ADDR_LSB]))
    else $error("Target field wrong");
  a_fwd_rnw: assert property (@(posedge CLK_SYS) disable iff (RST) TXN_VALID && hit |=> FWD_RNW == $past(TXN_RNW))
    else $error("Direction lost");

  a_miss_addr_zero: assert property (@(posedge CLK_SYS) disable iff (RST)
    MISS |-> FWD_ADDR == ALIAS_OFF)
    else $error("Address shown on miss");

  a_miss_follows: assert property (@(posedge CLK_SYS) disable iff (RST)
    TXN_VALID && !hit |=> MISS && !FWD_VALID)
    else $error("Miss not flagged");

  a_miss_no_ack: assert property (@(posedge CLK_SYS) disable iff (RST)
    MISS |-> !AUTO_ACK)
    else $error("Auto ack on miss");

  a_ack_follows: assert property (@(posedge CLK_SYS) disable iff (RST)
    TXN_VALID && hit && hit_ack && !TXN_RNW |=> AUTO_ACK)
    else $error("Auto ack missing");

  a_no_ack_clear: assert property (@(posedge CLK_SYS) disable iff (RST)
    TXN_VALID && hit && !hit_ack |=> !AUTO_ACK)
    else $error("Auto ack with bit clear");

  a_idle_quiet: assert property (@(posedge CLK_SYS) disable iff (RST)
    !TXN_VALID |=> !FWD_VALID && !MISS && !AUTO_ACK)
    else $error("Output without request");

  // Register file
  a_write_lands: assert property (@(posedge CLK_SYS) disable iff (RST)
    REG_WR && slot_of(REG_ADDR) == 3'h0 |=> alias_reg[$past(PORT_SEL)][0] == $past(REG_WDATA))
    else $error("Write lost");

  a_other_port_kept: assert property (@(posedge CLK_SYS) disable iff (RST)
    REG_WR && PORT_SEL != 2'h0 |=> alias_reg[0][0] == $past(alias_reg[0][0]))
    else $error("Write reached wrong port");

  a_read_six: assert property (@(posedge CLK_SYS) disable iff (RST)
    REG_ADDR == OFS_ALIAS_SIX && !REG_WR |=> REG_RDATA == alias_reg[$past(PORT_SEL)][4])
    else $error("Slot six read wrong");

  a_unmapped_read: assert property (@(posedge CLK_SYS) disable iff (RST)
    slot_of(REG_ADDR) == 3'h7 |=> REG_RDATA == ALIAS_RESET)
    else $error("Unmapped read not zero");

  a_slot_reset: assert property (@(posedge CLK_SYS)
    $past(RST) |-> alias_reg[0][0] == ALIAS_RESET && alias_reg[3][4] == ALIAS_RESET)
    else $error("Slot not cleared by reset");

  // Main scenarios
  c_fwd: cover property (@(posedge CLK_SYS) FWD_VALID);
  c_ack: cover property (@(posedge CLK_SYS) AUTO_ACK);
  c_miss: cover property (@(posedge CLK_SYS) MISS);
  c_fwd_read: cover property (@(posedge CLK_SYS) FWD_VALID && FWD_RNW);
  c_port_write: cover property (@(posedge CLK_SYS) REG_WR && PORT_SEL != 2'h0);
endmodule

//--- dv/rtar_host.sv
// Local controller model issuing address phases
`timescale 1ns/1ns
module rtar_host (
  input wire logic clk,
  output logic valid,
  output logic [6:0] addr,
  output logic rnw,
  output rtar_pkg::rtar_port_type port
);
  import rtar_pkg::*;
  initial begin
    valid = 1'b0;
    addr = 7'h00;
    rnw = 1'b0;
    port = 2'h0;
  end
  // Released address is inverted so a stale value never looks valid
  task automatic send(input logic [6:0] a, input logic r, input rtar_port_type p);
    @(negedge clk);
    {valid, addr, rnw, port} = {1'b1, a, r, p};
    @(negedge clk);
    {valid, addr} = {1'b0, ~a};
  endtask
endmodule

//--- dv/tb_top.sv
// Self-checking bench for the alias remap decoder
`timescale 1ns/1ns
module tb_top;
  import rtar_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wr_en = 1'b0, t_v, t_r, f_v, f_r, ack, miss;
  logic [7:0] r_a = 8'h00, r_d = 8'h00, r_q;
  logic [1:0] sel = 2'h0;
  logic [4:0][7:0] tid = {8'hA8, 8'h96, 8'h84, 8'h72, 8'h60};
  logic [6:0] t_a, f_a;
  rtar_port_type t_p;
  int fails = 0, comparisons = 0;
  always #20 clk = ~clk;
  rtar_remap rtar_remap_inst (.CLK_SYS(clk), .RST(rst), .REG_WR(wr_en), .REG_ADDR(r_a), .REG_WDATA(r_d),
    .REG_RDATA(r_q), .PORT_SEL(sel), .TARGET_ID(tid), .TXN_VALID(t_v), .TXN_ADDR(t_a), .TXN_RNW(t_r),
    .TXN_PORT(t_p), .FWD_VALID(f_v), .FWD_ADDR(f_a), .FWD_RNW(f_r), .AUTO_ACK(ack), .MISS(miss));
  rtar_host rtar_host_inst (.clk(clk), .valid(t_v), .addr(t_a), .rnw(t_r), .port(t_p));
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] p);
    @(negedge clk);
    {wr_en, r_a, r_d, sel} = {1'b1, a, d, p};
    @(negedge clk);
    wr_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] p, input logic [7:0] exp);
    @(negedge clk);
    {r_a, sel} = {a, p};
    @(negedge clk);
    check({2'h0, r_q}, {2'h0, exp});
  endtask
  task automatic txn(input logic [6:0] a, input logic r, input logic [1:0] p, input logic [9:0] exp);
    rtar_host_inst.send(a, r, p);
    check({f_v, miss, ack, f_a}, exp);
  endtask
  task automatic finish_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    finish_test();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 5; i++) rd(OFS_ALIAS_TWO + 8'(i), 2'h1, ALIAS_RESET);
    rd(8'h6C, 2'h1, 8'h00);
    $display("reset values done");
    wr(OFS_ALIAS_TWO, 8'h55, 2'h1);
    wr(OFS_ALIAS_SIX, 8'h34, 2'h1);
    rd(OFS_ALIAS_TWO, 2'h1, 8'h55);
    rd(OFS_ALIAS_TWO, 2'h2, 8'h00);
    $display("register access done");
    txn(7'h2A, 1'b0, 2'h1, {3'b101, 7'h30});
    txn(7'h2A, 1'b1, 2'h1, {3'b100, 7'h30});
    check({9'h000, f_r}, 10'h001);
    txn(7'h1A, 1'b0, 2'h1, {3'b100, 7'h54});
    txn(7'h2A, 1'b0, 2'h2, {3'b010, 7'h00});
    txn(7'h00, 1'b0, 2'h1, {3'b010, 7'h00});
    $display("remap done");
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd(OFS_ALIAS_TWO, 2'h1, ALIAS_RESET);
    txn(7'h2A, 1'b0, 2'h1, {3'b010, 7'h00});
    $display("mid-run reset done");
    finish_test();
  end
endmodule
